// ===== include/usb_dev_pkg.sv
// constants for the usb device event and control block
//------------------------------------------------------------
// Behaviour
// - iso IN read of an empty bank raises the endpoint underflow flag
// - OUT packet with all banks full is dropped and flags underflow
// - OUT crc error sets stalled/error flag and still sets out received
// - oversize OUT: overflow flag, ack, out received, keep leading bytes
// - frame start flag set on every start of frame packet
// - frame crc error bit updated together with frame start flag
// - 11-bit frame number captured from last sof, split high and low
// - event flags set regardless of their enable bits
// - software clears flags; writing one to set a flag is ignored
// - one enable per event; bus reset end enable resets set
// - speed bit: 0 full speed d+ pullup, 1 low speed d- pullup
// - remote wakeup only while suspended; hardware clears it when done
// - detach bit removes the pullup; clearing reconnects it
// - upstream resume flag set while driving resume to host
// - resume end flag set on valid host resume end
// - line wake flag on filtered activity, not own upstream resume
// - bus reset end flag set at end of usb bus reset
// - address enable set by software, cleared only by hardware
// - seven endpoint fifo clear bits, set then cleared by firmware
// - endpoint irq on normal events and on exceptions
//------------------------------------------------------------
package usb_dev_pkg;
  // register byte addresses
  localparam logic [4:0] ADDR_CONTROL = 5'h00;
  localparam logic [4:0] ADDR_FLAGS = 5'h04;
  localparam logic [4:0] ADDR_ENABLES = 5'h08;
  localparam logic [4:0] ADDR_ADDRESS = 5'h0c;
  localparam logic [4:0] ADDR_FRAME_HI = 5'h10;
  localparam logic [4:0] ADDR_FRAME_LO = 5'h14;
  localparam logic [4:0] ADDR_FRAME_ERR = 5'h18;
  localparam logic [4:0] ADDR_EP_SELECT = 5'h1c;
  localparam logic [5:0] ADDR_FIFO_RESET = 6'h20;
  localparam logic [5:0] ADDR_EP_FLAGS = 6'h24;
  localparam logic [5:0] ADDR_EP_ENABLES = 6'h28;
  // control fields
  localparam int CTL_DETACH = 0;
  localparam int CTL_WAKEUP = 1;
  localparam int CTL_LOW_SPEED = 2;
  // device event flag positions
  localparam int EV_SUSPEND = 0;
  localparam int EV_SOF = 2;
  localparam int EV_RESET_END = 3;
  localparam int EV_LINE_WAKE = 4;
  localparam int EV_RESUME_END = 5;
  localparam int EV_UP_RESUME = 6;
  localparam logic [7:0] EV_MASK = 8'h7d;
  localparam logic [7:0] EN_RESET = 8'h08;
  localparam int ADDR_ACTIVATE = 7;
  localparam int FRAME_ERR_BIT = 4;
  // endpoint flag positions
  localparam int EP_IN_READY = 0;
  localparam int EP_STALLED = 1;
  localparam int EP_OUT_RX = 2;
  localparam int EP_SETUP_RX = 3;
  localparam int EP_NAK_OUT = 4;
  localparam int EP_NAK_IN = 5;
  localparam int EP_UNDERFLOW = 6;
  localparam int EP_OVERFLOW = 7;
  // timing
  localparam int CLK_MHZ = 125;
  localparam int SUSPEND_MS = 3;
  localparam int SUSPEND_CYCLES = SUSPEND_MS * 1000 * CLK_MHZ;
  localparam int RESUME_MS = 1;
  localparam int RESUME_CYCLES = RESUME_MS * 1000 * CLK_MHZ;
endpackage : usb_dev_pkg

// ===== design/ep_event_flags.sv
// per-endpoint event flags and endpoint interrupt
`timescale 1ns/1ps
module ep_event_flags
  import usb_dev_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic fifo_clear_i,
  input wire logic in_ready_i,
  input wire logic stall_sent_i,
  input wire logic out_done_i,
  input wire logic out_crc_err_i,
  input wire logic out_oversize_i,
  input wire logic setup_done_i,
  input wire logic nak_in_i,
  input wire logic nak_out_i,
  input wire logic iso_i,
  input wire logic in_bank_empty_i,
  input wire logic out_banks_full_i,
  input wire logic [7:0] clear_i,
  input wire logic [7:0] enable_i,
  output logic [7:0] flags_o,
  output logic ack_out_o,
  output logic drop_out_o,
  output logic endpoint_irq_o
);
  logic [7:0] set_ev;
  logic drop;

  assign drop = out_done_i && out_banks_full_i;

  always_comb begin
    set_ev = 8'h00;
    set_ev[EP_IN_READY] = in_ready_i;
    set_ev[EP_STALLED] = stall_sent_i || (out_done_i && out_crc_err_i
                         && !drop);
    set_ev[EP_OUT_RX] = out_done_i && !drop;
    set_ev[EP_SETUP_RX] = setup_done_i;
    set_ev[EP_NAK_OUT] = nak_out_i;
    set_ev[EP_NAK_IN] = nak_in_i;
    set_ev[EP_UNDERFLOW] = (iso_i && nak_in_i && in_bank_empty_i)
                           || drop;
    set_ev[EP_OVERFLOW] = out_done_i && out_oversize_i && !drop;
  end

  // set wins over a software clear in the same cycle; a fifo clear wins over set
  always_ff @(posedge clk_i) begin
    if (rst_i || fifo_clear_i) begin
      flags_o <= 8'h00;
    end else begin
      flags_o <= (flags_o & ~clear_i) | set_ev;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_out_o <= 1'b0;
      drop_out_o <= 1'b0;
    end else begin
      ack_out_o <= out_done_i && !drop;
      drop_out_o <= drop;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      endpoint_irq_o <= 1'b0;
    end else begin
      endpoint_irq_o <= |(flags_o & enable_i);
    end
  end

  property p_underflow_in;
    @(posedge clk_i) disable iff (rst_i)
    iso_i && nak_in_i && in_bank_empty_i && !fifo_clear_i
    |=> flags_o[EP_UNDERFLOW];
  endproperty
  a_underflow_in: assert property (p_underflow_in)
    else $error("underflow flag missing");
  property p_nak_in;
    @(posedge clk_i) disable iff (rst_i)
    nak_in_i && !fifo_clear_i |=> flags_o[EP_NAK_IN];
  endproperty
  a_nak_in: assert property (p_nak_in)
    else $error("nak in flag missing");
  property p_drop_full;
    @(posedge clk_i) disable iff (rst_i)
    out_done_i && out_banks_full_i |=> drop_out_o && !ack_out_o;
  endproperty
  a_drop_full: assert property (p_drop_full)
    else $error("full banks packet not dropped");
  property p_crc_out;
    @(posedge clk_i) disable iff (rst_i)
    out_done_i && out_crc_err_i && !out_banks_full_i && !fifo_clear_i
    |=> flags_o[EP_STALLED] && flags_o[EP_OUT_RX];
  endproperty
  a_crc_out: assert property (p_crc_out)
    else $error("crc error flags wrong");
  property p_oversize;
    @(posedge clk_i) disable iff (rst_i)
    out_done_i && out_oversize_i && !out_banks_full_i && !fifo_clear_i
    |=> flags_o[EP_OVERFLOW] && ack_out_o;
  endproperty
  a_oversize: assert property (p_oversize)
    else $error("overflow not flagged");
  property p_ep_irq;
    @(posedge clk_i) disable iff (rst_i)
    |(flags_o & enable_i) |=> endpoint_irq_o;
  endproperty
  a_ep_irq: assert property (p_ep_irq)
    else $error("endpoint irq missing");
endmodule : ep_event_flags

// ===== design/usb_device_events_and_control.sv
// device level events, control registers and wishbone slave
`timescale 1ns/1ps
module usb_device_events_and_control
  import usb_dev_pkg::*;
#(
  parameter int SUSPEND_COUNT = SUSPEND_CYCLES,
  parameter int RESUME_COUNT = RESUME_CYCLES,
  parameter int NUM_EP = 7
) (
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [5:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // link events from the usb engine
  input wire logic line_idle_i,
  input wire logic line_activity_i,
  input wire logic host_resume_end_i,
  input wire logic bus_reset_end_i,
  input wire logic sof_i,
  input wire logic sof_crc_err_i,
  input wire logic [10:0] sof_frame_i,
  input wire logic host_mode_i,
  // endpoint events, one bit per endpoint
  input wire logic [NUM_EP-1:0] ep_in_ready_i,
  input wire logic [NUM_EP-1:0] ep_stall_sent_i,
  input wire logic [NUM_EP-1:0] ep_out_done_i,
  input wire logic [NUM_EP-1:0] ep_out_crc_err_i,
  input wire logic [NUM_EP-1:0] ep_out_oversize_i,
  input wire logic [NUM_EP-1:0] ep_setup_done_i,
  input wire logic [NUM_EP-1:0] ep_nak_in_i,
  input wire logic [NUM_EP-1:0] ep_nak_out_i,
  input wire logic [NUM_EP-1:0] ep_iso_i,
  input wire logic [NUM_EP-1:0] ep_in_bank_empty_i,
  input wire logic [NUM_EP-1:0] ep_out_banks_full_i,
  // outputs
  output logic dp_pullup_o,
  output logic dm_pullup_o,
  output logic resume_drive_o,
  output logic [6:0] device_address_o,
  output logic address_valid_o,
  output logic [2:0] endpoint_index_o,
  output logic [NUM_EP-1:0] endpoint_fifo_clear_o,
  output logic [NUM_EP-1:0] ep_ack_out_o,
  output logic [NUM_EP-1:0] ep_drop_out_o,
  output logic [NUM_EP-1:0] endpoint_irq_o,
  output logic device_irq_o
);
  //------------------------------------------------------------
  // registers
  //------------------------------------------------------------
  logic detach;
  logic remote_wakeup_request;
  logic low_speed_select;
  logic [7:0] dev_flags;
  logic [7:0] dev_enables;
  logic [6:0] device_address_value;
  logic address_activate;
  logic [10:0] frame_number;
  logic frame_number_crc_error;
  logic [7:0] next_dev_flags;
  logic [7:0] ep_clear [NUM_EP];
  logic [7:0] ep_enables [NUM_EP];
  logic [7:0] ep_flags [NUM_EP];
  logic [31:0] idle_count;
  logic [31:0] resume_count;
  logic suspend_hit;
  logic resume_done;
  logic wr;
  logic rd_req;
  logic [31:0] next_dat;

  assign wr = cyc_i && stb_i && we_i && !ack_o && sel_i[0];
  assign rd_req = cyc_i && stb_i && !ack_o;

  //------------------------------------------------------------
  // bus handshake: ack one cycle after the request
  //------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= rd_req;
      dat_o <= rd_req ? next_dat : 32'h0000_0000;
    end
  end

  // read mux
  always_comb begin
    next_dat = 32'h0000_0000;
    if (adr_i == {1'b0, ADDR_CONTROL}) begin
      next_dat[2:0] = {low_speed_select, remote_wakeup_request, detach};
    end else if (adr_i == {1'b0, ADDR_FLAGS}) begin
      next_dat[7:0] = dev_flags;
    end else if (adr_i == {1'b0, ADDR_ENABLES}) begin
      next_dat[7:0] = dev_enables;
    end else if (adr_i == {1'b0, ADDR_ADDRESS}) begin
      next_dat[7:0] = {address_activate, device_address_value};
    end else if (adr_i == {1'b0, ADDR_FRAME_HI}) begin
      next_dat[2:0] = frame_number[10:8];
    end else if (adr_i == {1'b0, ADDR_FRAME_LO}) begin
      next_dat[7:0] = frame_number[7:0];
    end else if (adr_i == {1'b0, ADDR_FRAME_ERR}) begin
      next_dat[FRAME_ERR_BIT] = frame_number_crc_error;
    end else if (adr_i == {1'b0, ADDR_EP_SELECT}) begin
      next_dat[2:0] = endpoint_index_o;
    end else if (adr_i == ADDR_FIFO_RESET) begin
      next_dat[NUM_EP-1:0] = endpoint_fifo_clear_o;
    end else if (adr_i == ADDR_EP_FLAGS) begin
      next_dat[7:0] = (endpoint_index_o < 3'(NUM_EP))
                      ? ep_flags[endpoint_index_o] : 8'h00;
    end else if (adr_i == ADDR_EP_ENABLES) begin
      next_dat[7:0] = (endpoint_index_o < 3'(NUM_EP))
                      ? ep_enables[endpoint_index_o] : 8'h00;
    end
  end

  //------------------------------------------------------------
  // control register
  //------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      detach <= 1'b1;
      low_speed_select <= 1'b0;
    end else if (wr && adr_i == {1'b0, ADDR_CONTROL}) begin
      detach <= dat_i[CTL_DETACH];
      low_speed_select <= dat_i[CTL_LOW_SPEED];
    end
  end

  // remote wakeup: set only while suspended, cleared by hardware
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      remote_wakeup_request <= 1'b0;
    end else if (resume_done) begin
      remote_wakeup_request <= 1'b0;
    end else if (wr && adr_i == {1'b0, ADDR_CONTROL} && dat_i[CTL_WAKEUP]
                 && dev_flags[EV_SUSPEND]) begin
      remote_wakeup_request <= 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || !remote_wakeup_request) begin
      resume_count <= 32'h0000_0000;
    end else begin
      resume_count <= resume_count + 32'h0000_0001;
    end
  end
  assign resume_done = remote_wakeup_request
                       && resume_count == 32'(RESUME_COUNT - 1);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      resume_drive_o <= 1'b0;
    end else begin
      resume_drive_o <= remote_wakeup_request && !resume_done;
    end
  end

  // pull-up choice by speed, removed on detach or in host mode
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dp_pullup_o <= 1'b0;
      dm_pullup_o <= 1'b0;
    end else begin
      dp_pullup_o <= !detach && !host_mode_i
                     && !low_speed_select;
      dm_pullup_o <= !detach && !host_mode_i
                     && low_speed_select;
    end
  end

  //------------------------------------------------------------
  // device event flags
  //------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i || !line_idle_i) begin
      idle_count <= 32'h0000_0000;
    end else if (idle_count != 32'(SUSPEND_COUNT)) begin
      idle_count <= idle_count + 32'h0000_0001;
    end
  end
  assign suspend_hit = line_idle_i
                       && idle_count == 32'(SUSPEND_COUNT - 1);

  always_comb begin
    next_dev_flags = dev_flags;
    if (wr && adr_i == {1'b0, ADDR_FLAGS}) begin
      next_dev_flags = dev_flags & dat_i[7:0];
    end
    next_dev_flags[EV_SUSPEND] = next_dev_flags[EV_SUSPEND] || suspend_hit;
    next_dev_flags[EV_SOF] = next_dev_flags[EV_SOF] || sof_i;
    next_dev_flags[EV_RESET_END] = next_dev_flags[EV_RESET_END]
                                   || bus_reset_end_i;
    next_dev_flags[EV_LINE_WAKE] = next_dev_flags[EV_LINE_WAKE]
      || (line_activity_i && !remote_wakeup_request);
    next_dev_flags[EV_RESUME_END] = next_dev_flags[EV_RESUME_END]
                                    || host_resume_end_i;
    next_dev_flags[EV_UP_RESUME] = next_dev_flags[EV_UP_RESUME]
                                   || remote_wakeup_request;
    next_dev_flags = next_dev_flags & EV_MASK;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dev_flags <= 8'h00;
    end else begin
      dev_flags <= next_dev_flags;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dev_enables <= EN_RESET;
    end else if (wr && adr_i == {1'b0, ADDR_ENABLES}) begin
      dev_enables <= dat_i[7:0] & EV_MASK;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      device_irq_o <= 1'b0;
    end else begin
      device_irq_o <= |(dev_flags & dev_enables);
    end
  end

  //------------------------------------------------------------
  // frame number capture
  //------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      frame_number <= 11'h000;
      frame_number_crc_error <= 1'b0;
    end else if (sof_i) begin
      frame_number <= sof_frame_i;
      frame_number_crc_error <= sof_crc_err_i;
    end
  end

  //------------------------------------------------------------
  // address, endpoint select, fifo clear
  //------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      device_address_value <= 7'h00;
      address_activate <= 1'b0;
    end else if (wr && adr_i == {1'b0, ADDR_ADDRESS}) begin
      device_address_value <= dat_i[6:0];
      address_activate <= address_activate
                          || dat_i[ADDR_ACTIVATE];
    end else if (address_activate) begin
      address_activate <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      device_address_o <= 7'h00;
      address_valid_o <= 1'b0;
    end else if (bus_reset_end_i) begin
      device_address_o <= 7'h00;
      address_valid_o <= 1'b0;
    end else if (address_activate) begin
      device_address_o <= device_address_value;
      address_valid_o <= 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      endpoint_index_o <= 3'h0;
      endpoint_fifo_clear_o <= '0;
    end else begin
      if (wr && adr_i == {1'b0, ADDR_EP_SELECT}) begin
        endpoint_index_o <= dat_i[2:0];
      end
      if (wr && adr_i == ADDR_FIFO_RESET) begin
        endpoint_fifo_clear_o <= dat_i[NUM_EP-1:0];
      end
    end
  end

  //------------------------------------------------------------
  // endpoints
  //------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NUM_EP; g++) begin : g_ep
      always_comb begin
        ep_clear[g] = 8'h00;
        if (wr && adr_i == ADDR_EP_FLAGS && endpoint_index_o == 3'(g)) begin
          ep_clear[g] = ~dat_i[7:0];
        end
      end
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          ep_enables[g] <= 8'h00;
        end else if (wr && adr_i == ADDR_EP_ENABLES
                     && endpoint_index_o == 3'(g)) begin
          ep_enables[g] <= dat_i[7:0];
        end
      end
      ep_event_flags u_ep (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .fifo_clear_i(endpoint_fifo_clear_o[g]),
        .in_ready_i(ep_in_ready_i[g]),
        .stall_sent_i(ep_stall_sent_i[g]),
        .out_done_i(ep_out_done_i[g]),
        .out_crc_err_i(ep_out_crc_err_i[g]),
        .out_oversize_i(ep_out_oversize_i[g]),
        .setup_done_i(ep_setup_done_i[g]),
        .nak_in_i(ep_nak_in_i[g]),
        .nak_out_i(ep_nak_out_i[g]),
        .iso_i(ep_iso_i[g]),
        .in_bank_empty_i(ep_in_bank_empty_i[g]),
        .out_banks_full_i(ep_out_banks_full_i[g]),
        .clear_i(ep_clear[g]),
        .enable_i(ep_enables[g]),
        .flags_o(ep_flags[g]),
        .ack_out_o(ep_ack_out_o[g]),
        .drop_out_o(ep_drop_out_o[g]),
        .endpoint_irq_o(endpoint_irq_o[g])
      );
    end
  endgenerate

  //------------------------------------------------------------
  // checks
  //------------------------------------------------------------
  property p_sof_flag;
    @(posedge clk_i) disable iff (rst_i)
    sof_i |=> dev_flags[EV_SOF]
              && frame_number_crc_error == $past(sof_crc_err_i);
  endproperty
  a_sof_flag: assert property (p_sof_flag)
    else $error("sof flag or crc bit wrong");
  property p_frame_crc;
    @(posedge clk_i) disable iff (rst_i)
    !sof_i |=> $stable(frame_number_crc_error);
  endproperty
  a_frame_crc: assert property (p_frame_crc)
    else $error("crc bit moved without sof");
  property p_frame_num;
    @(posedge clk_i) disable iff (rst_i)
    sof_i |=> frame_number == $past(sof_frame_i);
  endproperty
  a_frame_num: assert property (p_frame_num)
    else $error("frame number not captured");
  property p_suspend;
    @(posedge clk_i) disable iff (rst_i)
    suspend_hit |=> dev_flags[EV_SUSPEND];
  endproperty
  a_suspend: assert property (p_suspend)
    else $error("suspend flag missing");
  property p_no_sw_set;
    @(posedge clk_i) disable iff (rst_i)
    !dev_flags[EV_RESET_END] && !bus_reset_end_i |=> !dev_flags[EV_RESET_END];
  endproperty
  a_no_sw_set: assert property (p_no_sw_set)
    else $error("flag set without event");
  property p_irq;
    @(posedge clk_i) disable iff (rst_i)
    |(dev_flags & dev_enables) |=> device_irq_o;
  endproperty
  a_irq: assert property (p_irq)
    else $error("device irq missing");
  property p_addr_clear;
    @(posedge clk_i) disable iff (rst_i)
    address_activate && !wr && !bus_reset_end_i
    |=> !address_activate ##0 address_valid_o;
  endproperty
  a_addr_clear: assert property (p_addr_clear)
    else $error("address activate not cleared");
  property p_pullup;
    @(posedge clk_i) disable iff (rst_i)
    detach |=> !dp_pullup_o && !dm_pullup_o;
  endproperty
  a_pullup: assert property (p_pullup)
    else $error("pullup on while detached");
endmodule : usb_device_events_and_control

// ===== bench/usb_host_model.sv
// host side model: drives link events toward the device block
`timescale 1ns/1ps
module usb_host_model (
  input wire logic clk_i,
  output logic line_idle_o,
  output logic line_act_o,
  output logic rsm_end_o,
  output logic rst_end_o,
  output logic sof_o,
  output logic sof_err_o,
  output logic [10:0] frame_o
);
  initial begin
    {line_idle_o, line_act_o, rsm_end_o, rst_end_o} = 4'h0;
    {sof_o, sof_err_o, frame_o} = 13'h0;
  end
  task automatic send_sof(input logic [10:0] fr, input logic err);
    @(posedge clk_i);
    sof_o <= 1'b1;
    sof_err_o <= err;
    frame_o <= fr;
    @(posedge clk_i);
    sof_o <= 1'b0;
    sof_err_o <= ~err;
    frame_o <= ~fr;
  endtask : send_sof
  // one-cycle pulse of activity, resume end, bus reset end
  task automatic ev(input logic [2:0] m);
    @(posedge clk_i);
    {line_act_o, rsm_end_o, rst_end_o} <= m;
    @(posedge clk_i);
    {line_act_o, rsm_end_o, rst_end_o} <= 3'h0;
  endtask : ev
  task automatic idle(input int n);
    @(posedge clk_i);
    line_idle_o <= 1'b1;
    repeat (n) @(posedge clk_i);
    line_idle_o <= 1'b0;
  endtask : idle
endmodule : usb_host_model

// ===== bench/usb_device_events_and_control_tb.sv
// self-checking bench for the usb device event and control block
`timescale 1ns/1ps
module usb_device_events_and_control_tb;
  logic clk_i, rst_i, req, we, ack, dp, dm, rdrv, aval, irq;
  logic [5:0] adr;
  logic [31:0] wdat, rdat;
  logic [6:0] dadr, fclr, ack_out, drop, ep_irq;
  logic [2:0] epi;
  logic [6:0] ep_od = '0, ep_crc = '0, ep_ov = '0, ep_ni = '0, ep_bf = '0;
  logic [6:0] ep_st = '0, ep_iso = '0, ep_be = '0;
  logic [6:0] ep_ir = '0, ep_su = '0, ep_no = '0;
  logic hm = 1'b0;
  logic idle, act, rsm, rend, sof, serr;
  logic [10:0] fr;
  int mismatches = 0;
  int n_compared = 0;
  usb_host_model i_host (.clk_i(clk_i), .line_idle_o(idle), .line_act_o(act),
    .rsm_end_o(rsm), .rst_end_o(rend), .sof_o(sof), .sof_err_o(serr),
    .frame_o(fr));
  usb_device_events_and_control #(.SUSPEND_COUNT(20), .RESUME_COUNT(10))
  i_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(req), .stb_i(req), .we_i(we),
    .adr_i(adr), .sel_i(4'h1), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
    .line_idle_i(idle), .line_activity_i(act), .host_resume_end_i(rsm),
    .bus_reset_end_i(rend), .sof_i(sof), .sof_crc_err_i(serr),
    .sof_frame_i(fr), .host_mode_i(hm), .ep_in_ready_i(ep_ir),
    .ep_stall_sent_i(ep_st), .ep_out_done_i(ep_od), .ep_out_crc_err_i(ep_crc),
    .ep_out_oversize_i(ep_ov), .ep_setup_done_i(ep_su), .ep_nak_in_i(ep_ni),
    .ep_nak_out_i(ep_no), .ep_iso_i(ep_iso), .ep_in_bank_empty_i(ep_be),
    .ep_out_banks_full_i(ep_bf), .dp_pullup_o(dp), .dm_pullup_o(dm),
    .resume_drive_o(rdrv), .device_address_o(dadr), .address_valid_o(aval),
    .endpoint_index_o(epi), .endpoint_fifo_clear_o(fclr),
    .ep_ack_out_o(ack_out), .ep_drop_out_o(drop), .endpoint_irq_o(ep_irq),
    .device_irq_o(irq));
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  task automatic stop_test();
    if (mismatches == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : stop_test
  task automatic check(input string nm, input logic [7:0] e, g);
    n_compared++;
    if (g !== e) begin
      $display("[FAIL] %s exp %h got %h", nm, e, g);
      mismatches++;
    end
  endtask : check
  task automatic wb(input logic [5:0] a, input logic w, input logic [7:0] d,
                    output logic [7:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    req <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (n >= 20) begin
      mismatches++;
      stop_test();
    end
    q = rdat[7:0];
    req <= 1'b0;
  endtask : wb
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    logic [7:0] q;
    wb(a, 1'b1, d, q);
  endtask : wr
  task automatic rd(input logic [5:0] a, input logic [7:0] e,
                    input string nm, input logic [7:0] m = 8'hff);
    logic [7:0] q;
    wb(a, 1'b0, 8'h0, q);
    check(nm, e, q & m);
  endtask : rd
  task automatic t_reset();
    rd(6'h00, 8'h01, "control");
    rd(6'h08, 8'h08, "enables");
    check("pullups", 8'h0, {6'h0, dp, dm});
    wr(6'h1c, 8'h02);
    wr(6'h20, 8'h01);
    check("ep index", 8'h02, {5'h0, epi});
    check("fifo clr", 8'h01, {1'h0, fclr});
    wr(6'h20, 8'h00);
    wr(6'h1c, 8'h00);
  endtask : t_reset
  task automatic t_sof();
    wr(6'h08, 8'h04);
    i_host.send_sof(11'h5a3, 1'b1);
    rd(6'h04, 8'h04, "sof");
    rd(6'h10, 8'h05, "frame hi");
    rd(6'h14, 8'ha3, "frame lo");
    rd(6'h18, 8'h10, "crc err");
    check("irq", 8'h01, {7'h0, irq});
    i_host.send_sof(11'h0ff, 1'b0);
    rd(6'h18, 8'h00, "crc ok");
    wr(6'h04, 8'h00);
    wr(6'h04, 8'hff);
    rd(6'h04, 8'h00, "no set");
    check("irq off", 8'h00, {7'h0, irq});
    i_host.ev(3'b111);
    rd(6'h04, 8'h38, "events");
    check("masked", 8'h00, {7'h0, irq});
    wr(6'h04, 8'h00);
  endtask : t_sof
  task automatic t_ctl();
    wr(6'h00, 8'h00);
    @(posedge clk_i);
    check("full", 8'h02, {6'h0, dp, dm});
    wr(6'h00, 8'h04);
    @(posedge clk_i);
    check("low", 8'h01, {6'h0, dp, dm});
    hm <= 1'b1;
    repeat (2) @(posedge clk_i);
    check("host mode", 8'h00, {6'h0, dp, dm});
    hm <= 1'b0;
    wr(6'h00, 8'h07);
    rd(6'h00, 8'h05, "early wake");
    i_host.idle(24);
    rd(6'h04, 8'h01, "suspend");
    wr(6'h00, 8'h07);
    @(posedge clk_i);
    check("resume", 8'h01, {7'h0, rdrv});
    rd(6'h04, 8'h41, "up resume");
    repeat (14) @(posedge clk_i);
    rd(6'h00, 8'h05, "wake done");
    check("detach", 8'h00, {6'h0, dp, dm});
    wr(6'h0c, 8'h85);
    rd(6'h0c, 8'h05, "addr reg");
    check("address", 8'h85, {aval, dadr});
  endtask : t_ctl
  // m: in rdy, setup, nak out, out done, crc, oversize, nak in, full, stall
  task automatic ep(input logic [8:0] m, input logic [1:0] e,
                    input logic [7:0] f, input string nm);
    logic [1:0] s;
    @(posedge clk_i);
    {ep_ir[0], ep_su[0], ep_no[0], ep_od[0], ep_crc[0], ep_ov[0], ep_ni[0],
     ep_bf[0], ep_st[0]} <= m;
    @(posedge clk_i);
    {ep_ir[0], ep_su[0], ep_no[0], ep_od[0], ep_crc[0], ep_ov[0], ep_ni[0],
     ep_bf[0], ep_st[0]} <= 9'h000;
    @(posedge clk_i);
    s = {ack_out[0], drop[0]};
    rd(6'h24, f, nm, f);
    check(nm, {5'h0, e, 1'b1}, {5'h0, s, ep_irq[0]});
    wr(6'h24, 8'h00);
  endtask : ep
  initial begin
    rst_i = 1'b1;
    {req, we, adr, wdat} = '0;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_sof();
    t_ctl();
    wr(6'h28, 8'hff);
    ep(9'h030, 2'h2, 8'h06, "crc out");
    ep(9'h028, 2'h2, 8'h84, "oversize");
    ep(9'h022, 2'h1, 8'h40, "full");
    ep(9'h001, 2'h0, 8'h02, "stall");
    ep(9'h1c0, 2'h0, 8'h19, "normal");
    ep_iso[0] <= 1'b1;
    ep_be[0] <= 1'b1;
    ep(9'h004, 2'h0, 8'h40, "underflow");
    stop_test();
  end
endmodule : usb_device_events_and_control_tb
